/* logic/pwmovr_gen.v */
`timescale 1ns/1ps
`default_nettype none

// One generator: active while the time base is below the active duty.
module pwmovr_gen (
	input  wire        clk,
	input  wire        rst,
	input  wire [15:0] time_base,
	input  wire [15:0] duty,
	output reg         wave_ff
);

	// Registered compare keeps the waveform glitch free at the pins.
	always @(posedge clk) begin
		if (rst) begin
			wave_ff <= 1'b0;
		end else begin
			wave_ff <= (time_base < duty);
		end
	end

endmodule

`default_nettype wire

/* logic/pwmovr_map.vh */
`ifndef PWMOVR_MAP_VH
`define PWMOVR_MAP_VH

// Register word indices; the byte address is four times the index.
`define PWMOVR_ADDR_OVERRIDE 4'h0
`define PWMOVR_ADDR_DUTY1    4'h1
`define PWMOVR_ADDR_DUTY2    4'h2
`define PWMOVR_ADDR_DUTY3    4'h3
`define PWMOVR_ADDR_DUTY4    4'h4
`define PWMOVR_ADDR_CONTROL  4'h5
`define PWMOVR_ADDR_PERIOD   4'h6
`define PWMOVR_ADDR_TIMEBASE 4'h7

// Reset values.
`define PWMOVR_RST_OVERRIDE 16'hFF00
`define PWMOVR_RST_DUTY     16'h0000
`define PWMOVR_RST_CONTROL  2'h0
`define PWMOVR_RST_PERIOD   16'hFFFF

// Field positions.
`define PWMOVR_SEL_HI   15
`define PWMOVR_SEL_LO   8
`define PWMOVR_LVL_HI   7
`define PWMOVR_LVL_LO   0
`define PWMOVR_CTL_SYNC 1
`define PWMOVR_CTL_BUFFER_UPDATE_BLOCK 0

// AXI responses.
`define PWMOVR_RESP_OKAY   2'h0
`define PWMOVR_RESP_SLVERR 2'h2

`endif

/* logic/pwmovr_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "pwmovr_map.vh"

// Override stage and duty holding registers of a four pair PWM unit.
module pwmovr_top (
	input  wire        CORE_CLK,
	input  wire        RST,
	input  wire [31:0] S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [31:0] S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	output reg  [7:0]  PWM_OUT
);

	// Word index from a byte address; unmapped only when above top, low two bits ignored.
	function [3:0] word_idx;
		input [31:0] addr;
		begin
			// Unmapped addresses fall on an index that no register owns.
			word_idx = (addr[31:5] == 27'h0000000) ? addr[5:2] : 4'hF;
		end
	endfunction

	// True when a byte address names one of the mapped registers.
	function mapped;
		input [31:0] addr;
		begin
			mapped = (addr[31:5] == 27'h0000000);
		end
	endfunction

	// Merges write data into a 16 bit register by byte strobes.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge16[7:0]  = strb[0] ? data[7:0] : old[7:0];
			merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
		end
	endfunction

	reg  [15:0] ovr_ff;       // Override register as software wrote it.
	reg  [15:0] ovr_act_ff;   // Override value the pins obey.
	reg  [15:0] duty_buf_ff [0:3]; // Duty buffers seen by software.
	reg  [15:0] duty_act_ff [0:3]; // Duty values the generators use.
	reg  [15:0] period_ff;    // Period buffer.
	reg  [15:0] period_act_ff; // Active period.
	reg  [1:0]  ctl_ff;       // Sync select and update block bits.
	reg  [15:0] tb_ff;        // PWM time base.
	reg         aw_full_ff;   // Write address held.
	reg         w_full_ff;    // Write data held.
	reg  [31:0] awaddr_ff;    // Held write address.
	reg  [31:0] wdata_ff;     // Held write data.
	reg  [3:0]  wstrb_ff;     // Held write strobes.
	wire [7:0]  wave;         // Generator waveforms, pair order 4H..1L.
	wire        tb_wrap;      // Time base at end of period.
	wire        do_write;     // Both halves of a write are held.
	wire [3:0]  duty_sel;     // Duty buffer named by the held write address.
	integer     i;            // Loop index of the register file.
	integer     j;            // Loop index of the buffer transfer.
	integer     k;            // Loop index of the pin mux.

	// Duty words follow the override word, so index one is buffer zero.
	assign duty_sel      = word_idx(awaddr_ff) - 4'h1;

	assign tb_wrap       = (tb_ff >= period_act_ff);
	assign do_write      = aw_full_ff && w_full_ff && !S_AXI_BVALID;
	assign S_AXI_AWREADY = !aw_full_ff && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_full_ff && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	// Four generators; each pair drives its high and low pin together.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_pair
			pwmovr_gen u_gen (
				.clk       (CORE_CLK),
				.rst       (RST),
				.time_base (tb_ff),
				.duty      (duty_act_ff[g]),
				.wave_ff   (wave[2*g+1])
			);
			// Low side is the complement; dead time lives elsewhere.
			assign wave[2*g] = !wave[2*g+1];
		end
	endgenerate

	// Write channel: address and data are taken in either order.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			aw_full_ff   <= 1'b0;
			w_full_ff    <= 1'b0;
			awaddr_ff    <= 32'h00000000;
			wdata_ff     <= 32'h00000000;
			wstrb_ff     <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `PWMOVR_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full_ff <= 1'b1;
				awaddr_ff  <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full_ff <= 1'b1;
				wdata_ff  <= S_AXI_WDATA;
				wstrb_ff  <= S_AXI_WSTRB;
			end
			if (do_write) begin
				aw_full_ff   <= 1'b0;
				w_full_ff    <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= mapped(awaddr_ff) ? `PWMOVR_RESP_OKAY
				                                  : `PWMOVR_RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Register file; writes land one cycle after both halves are held.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ovr_ff    <= `PWMOVR_RST_OVERRIDE;
			ctl_ff    <= `PWMOVR_RST_CONTROL;
			period_ff <= `PWMOVR_RST_PERIOD;
			for (i = 0; i < 4; i = i + 1) begin
				duty_buf_ff[i] <= `PWMOVR_RST_DUTY;
			end
		end else if (do_write && mapped(awaddr_ff)) begin
			case (word_idx(awaddr_ff))
			`PWMOVR_ADDR_OVERRIDE: begin
				ovr_ff <= merge16(ovr_ff, wdata_ff, wstrb_ff);
			end
			`PWMOVR_ADDR_DUTY1, `PWMOVR_ADDR_DUTY2,
			`PWMOVR_ADDR_DUTY3, `PWMOVR_ADDR_DUTY4: begin
				duty_buf_ff[duty_sel[1:0]] <=
					merge16(duty_buf_ff[duty_sel[1:0]],
					        wdata_ff, wstrb_ff);
			end
			`PWMOVR_ADDR_CONTROL: begin
				if (wstrb_ff[0]) begin
					ctl_ff <= wdata_ff[1:0];
				end
			end
			`PWMOVR_ADDR_PERIOD: begin
				period_ff <= merge16(period_ff, wdata_ff, wstrb_ff);
			end
			default: begin
				// Time base is read only; other words ignore writes.
			end
			endcase
		end
	end

	// Time base and transfer of buffers into the active generator.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			tb_ff         <= 16'h0000;
			period_act_ff <= `PWMOVR_RST_PERIOD;
			for (j = 0; j < 4; j = j + 1) begin
				duty_act_ff[j] <= `PWMOVR_RST_DUTY;
			end
		end else begin
			tb_ff <= tb_wrap ? 16'h0000 : tb_ff + 16'h0001;
			// Transfers happen at period end so a cycle is never torn.
			if (tb_wrap && !ctl_ff[`PWMOVR_CTL_BUFFER_UPDATE_BLOCK]) begin
				period_act_ff <= period_ff;
				for (j = 0; j < 4; j = j + 1) begin
					duty_act_ff[j] <= duty_buf_ff[j];
				end
			end
		end
	end

	// Override transfer: at period end when synced, else next cycle.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ovr_act_ff <= `PWMOVR_RST_OVERRIDE;
		end else if (!ctl_ff[`PWMOVR_CTL_SYNC] || tb_wrap) begin
			ovr_act_ff <= ovr_ff;
		end
	end

	// Pin mux; bit k of each byte is the pin, 7 is pair 4 high.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			PWM_OUT <= 8'h00;
		end else begin
			// Pin k, wave k and bit k of each byte name the same output.
			for (k = 0; k < 8; k = k + 1) begin
				if (ovr_act_ff[`PWMOVR_SEL_LO + k]) begin
					PWM_OUT[k] <= wave[k];
				end else begin
					PWM_OUT[k] <= ovr_act_ff[`PWMOVR_LVL_LO + k];
				end
			end
		end
	end

	// Read channel: one cycle from address to data.
	always @(posedge CORE_CLK) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= `PWMOVR_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? `PWMOVR_RESP_OKAY
			                                     : `PWMOVR_RESP_SLVERR;
			case (word_idx(S_AXI_ARADDR))
			`PWMOVR_ADDR_OVERRIDE: S_AXI_RDATA <= {16'h0000, ovr_ff};
			`PWMOVR_ADDR_DUTY1:    S_AXI_RDATA <= {16'h0000, duty_buf_ff[0]};
			`PWMOVR_ADDR_DUTY2:    S_AXI_RDATA <= {16'h0000, duty_buf_ff[1]};
			`PWMOVR_ADDR_DUTY3:    S_AXI_RDATA <= {16'h0000, duty_buf_ff[2]};
			`PWMOVR_ADDR_DUTY4:    S_AXI_RDATA <= {16'h0000, duty_buf_ff[3]};
			`PWMOVR_ADDR_CONTROL:  S_AXI_RDATA <= {30'h00000000, ctl_ff};
			`PWMOVR_ADDR_PERIOD:   S_AXI_RDATA <= {16'h0000, period_ff};
			`PWMOVR_ADDR_TIMEBASE: S_AXI_RDATA <= {16'h0000, tb_ff};
			default:               S_AXI_RDATA <= 32'h00000000;
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* tb/pwm_output_override_duty_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwmovr_map.vh"
module pwm_output_override_duty_tb_top;
	logic CORE_CLK = 0, RST = 1, S_AXI_BREADY = 1, S_AXI_RREADY = 1;
	logic [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0;
	logic [31:0] S_AXI_RDATA, lf = 32'h00013146;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_ARVALID = 0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY;
	logic S_AXI_BVALID, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [7:0] PWM_OUT, gates;
	logic [33:0] exp_q[$];
	int miscompares = 0, n_compared = 0;
	pwmovr_top DUT (.*);
	pwmovr_gate_drv u_gate (.clk(CORE_CLK), .pins(PWM_OUT), .gates_ff(gates));
	always #5 CORE_CLK = ~CORE_CLK;
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Offers address and data together, releases each when taken.
	task automatic wr(input logic [31:0] a, v, input logic [1:0] r);
		logic aw, w;
		aw = 1;
		w = 1;
		exp_q.push_back({r, 32'h0});
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		do begin
			@(posedge CORE_CLK);
			if (aw && S_AXI_AWREADY) begin
				aw = 0;
				S_AXI_AWVALID <= 0;
			end
			if (w && S_AXI_WREADY) begin
				w = 0;
				S_AXI_WVALID <= 0;
			end
		end while (aw || w);
		do @(posedge CORE_CLK); while (!S_AXI_BVALID);
	endtask
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 0;
		do @(posedge CORE_CLK); while (!S_AXI_RVALID);
	endtask
	// Gives the override path time to reach the gates.
	task automatic pin(input logic [7:0] e);
		repeat (4) @(posedge CORE_CLK);
		#1 chk({26'h0, gates}, {26'h0, e});
		// Hand back on a clock edge so the next request starts there.
		@(posedge CORE_CLK);
	endtask
	// Answers are matched to the oldest note in the queue.
	always @(posedge CORE_CLK) begin
		if (S_AXI_BVALID) chk({S_AXI_BRESP, 32'h0}, exp_q.pop_front());
		if (S_AXI_RVALID) chk({S_AXI_RRESP, S_AXI_RDATA}, exp_q.pop_front());
	end
	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		// The reset period alone runs 65536 cycles before buffers move.
		#800000;
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge CORE_CLK);
		RST <= 0;
		pin(8'h55);
		rd(32'h0, 34'h0FF00);
		for (int i = 1; i < 5; i++) rd(32'(4 * i), 34'h0);
		for (int i = 1; i < 5; i++) begin
			lf = nxt(lf);
			wr(32'(4 * i), lf, 2'h0);
			rd(32'(4 * i), {18'h0, lf[15:0]});
		end
		$display("reset and duty tests done");
		lf = nxt(lf);
		wr(32'h0, {24'h0, lf[7:0]}, 2'h0);
		pin(lf[7:0]);
		wr(32'h0, 32'h0000F0AF, 2'h0);
		pin(8'h5F);
		rd(32'h0, 34'h0F0AF);
		$display("override tests done");
		wr(32'h40, 32'h0, 2'h2);
		rd(32'h40, {2'h2, 32'h0});
		$display("unmapped tests done");
		// Pair one full on, the others off, and a short period.
		wr(32'h0, 32'h0000FF00, 2'h0);
		wr(32'h4, 32'h0000FFFF, 2'h0);
		for (int i = 2; i < 5; i++) wr(32'(4 * i), 32'h0, 2'h0);
		wr(32'h18, 32'h0000003F, 2'h0);
		// The reset period must run out once before the buffers move.
		repeat (`PWMOVR_RST_PERIOD + 8) @(posedge CORE_CLK);
		pin(8'h56);
		wr(32'h14, 32'h1, 2'h0);
		rd(32'h14, 34'h1);
		wr(32'h4, 32'h0, 2'h0);
		repeat (140) @(posedge CORE_CLK);
		pin(8'h56);
		wr(32'h14, 32'h0, 2'h0);
		repeat (140) @(posedge CORE_CLK);
		pin(8'h55);
		$display("duty transfer tests done");
		wr(32'h4, 32'h00000010, 2'h0);
		wr(32'h14, 32'h2, 2'h0);
		repeat (140) @(posedge CORE_CLK);
		// Catch the start of a period so the next wrap is far off.
		while (PWM_OUT[1]) @(posedge CORE_CLK);
		while (!PWM_OUT[1]) @(posedge CORE_CLK);
		wr(32'h0, 32'h0, 2'h0);
		pin(8'h56);
		repeat (60) @(posedge CORE_CLK);
		pin(8'h00);
		$display("override sync tests done");
		RST <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(32'h0, 34'h0FF00);
		rd(32'h4, 34'h0);
		$display("second reset tests done");
		complete_run;
	end
endmodule
`default_nettype wire

/* tb/pwmovr_gate_drv.sv */
`timescale 1ns/1ps
`default_nettype none
// Gate driver stand-in: a pin at one switches its gate on a clock later.
module pwmovr_gate_drv (
	input  wire logic       clk,
	input  wire logic [7:0] pins,
	output var  logic [7:0] gates_ff
);
	// Active level one turns the switch on, zero turns it off.
	always @(posedge clk) begin
		gates_ff <= pins;
	end
endmodule
`default_nettype wire

/* tb/pwmovr_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus and pin relations seen only at the top ports.
module pwmovr_props (
	input wire logic        CORE_CLK,
	input wire logic        RST,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0]  S_AXI_WSTRB,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [7:0]  PWM_OUT
);
	// Both halves of a write taken at one edge.
	wire wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	wire rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	reset_quiet_a: assert property (
		$fell(RST) |-> PWM_OUT == 8'h00 && !S_AXI_BVALID && !S_AXI_RVALID)
		else $error("outputs not quiet after reset");
	write_resp_a: assert property (
		wr_go |-> ##2 S_AXI_BVALID) else $error("write answer late");
	read_resp_a: assert property (
		rd_go |=> S_AXI_RVALID) else $error("read answer late");
	read_busy_a: assert property (
		S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
	write_busy_a: assert property (
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while busy");
	bad_read_a: assert property (
		rd_go && S_AXI_ARADDR >= 32'h20 |=> S_AXI_RRESP == 2'h2
		&& S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
	good_read_a: assert property (
		rd_go && S_AXI_ARADDR < 32'h20 |=> S_AXI_RRESP == 2'h0)
		else $error("mapped read refused");
	bad_write_a: assert property (
		wr_go && S_AXI_AWADDR >= 32'h20 |-> ##2 S_AXI_BRESP == 2'h2)
		else $error("unmapped write not refused");
endmodule
bind pwmovr_top pwmovr_props u_props (.*);
`default_nettype wire
